// ==== dead_time_output_interlock.sv ====
// three-phase complementary output stage with dead time and interlock
//
// Contract
// - delay via fifteen-stage shift register, any tap
// - shift clock is crystal divided four or six
// - even divider setting four, odd six
// - dead time value 0..15, zero none
// - dead time equals value times shift period
// - source from transfer load until count zero
// - zero dead time gives exact complement pair
// - low output means transistor on
// - only activating edge delayed, never both low
// - inhibit high forces all outputs high
// - set pulse latches hold, outputs stay high
// - status output high while hold set
// - clear pulse releases hold, outputs resume; a set pulse in the same cycle wins and keeps hold set
// - three independent complementary output pairs
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dead_time_output_interlock
  import pwm_out_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              transfer_pin,
  input  wire logic              inhibit_pin,
  input  wire logic              set_status_pin,
  input  wire logic              clear_status_pin,
  output logic                   status_out,
  output logic                   irq,
  output logic                   phase_one_normal_drive,
  output logic                   phase_one_complement_drive,
  output logic                   phase_two_normal_drive,
  output logic                   phase_two_complement_drive,
  output logic                   phase_three_normal_drive,
  output logic                   phase_three_complement_drive
);

  pwm_ctrl_if ctl ();

  logic [DATA_W-1:0] phase_val_ff [NUM_CH];
  logic [DEAD_W-1:0] dead_ff;
  logic [DIV_W-1:0]  div_ff;
  logic [EV_W-1:0]   irq_stat_ff;
  logic [EV_W-1:0]   irq_mask_ff;
  logic [EV_W-1:0]   nxt_irq_stat;
  logic [EV_W-1:0]   nxt_irq_mask;
  logic [EV_W-1:0]   events;
  logic [DATA_W-1:0] reg_rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              irq_ff;

  logic [PIN_W-1:0]  pin_s1_ff;
  logic [PIN_W-1:0]  pin_s2_ff;
  logic [PIN_W-1:0]  pin_s3_ff;
  logic [PIN_W-1:0]  pin_filt_ff;
  logic [PIN_W-1:0]  pin_prev_ff;
  logic [PIN_W-1:0]  pin_now;

  logic [PRE_W-1:0]  pre_cnt_ff;
  logic [DLY_W-1:0]  dly_cnt_ff;
  logic              cnt_tick_ff;
  logic              dly_tick_ff;
  logic              xfer_ff;
  logic              div_wr;

  logic              hold_ff;
  logic              nxt_hold;
  logic              force_high;
  logic [NUM_CH-1:0] src;
  logic [NUM_CH-1:0] dly;
  logic [NUM_CH-1:0] norm_n_ff;
  logic [NUM_CH-1:0] comp_n_ff;

  // ---------------- register port ----------------
  assign div_wr = reg_wr && reg_addr == OFF_DIV;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        phase_val_ff[i] <= RST_PHASE;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr == ADDR_W'(i)) begin
          phase_val_ff[i] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dead_ff <= RST_DEAD;
      div_ff  <= RST_DIV;
    end else if (reg_wr) begin
      if (reg_addr == OFF_DEAD) begin
        dead_ff <= reg_wdata[DEAD_W-1:0];
      end
      if (div_wr) begin
        div_ff <= reg_wdata[DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_mask_ff <= RST_EV;
    end else if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
      irq_mask_ff <= reg_wdata[EV_W-1:0];
    end
  end

  // read mux, data valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr)
      OFF_PHASE1:   nxt_rdata = phase_val_ff[0];
      OFF_PHASE2:   nxt_rdata = phase_val_ff[1];
      OFF_PHASE3:   nxt_rdata = phase_val_ff[2];
      OFF_DEAD:     nxt_rdata[DEAD_W-1:0] = dead_ff;
      OFF_DIV:      nxt_rdata[DIV_W-1:0] = div_ff;
      OFF_IRQ_STAT: nxt_rdata[EV_W-1:0] = irq_stat_ff;
      OFF_IRQ_MASK: nxt_rdata[EV_W-1:0] = irq_mask_ff;
      default: begin
        nxt_rdata[LIVE_HOLD] = hold_ff;
        nxt_rdata[LIVE_INH] = pin_filt_ff[PIN_INH];
        nxt_rdata[LIVE_SRC +: NUM_CH] = src;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : '0;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ---------------- pin synchronisers ----------------
  assign pin_now = {clear_status_pin, set_status_pin,
                    inhibit_pin, transfer_pin};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= pin_now;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_filt_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_filt_ff <= (~(pin_s2_ff ^ pin_s3_ff) & pin_s3_ff)
                   | ((pin_s2_ff ^ pin_s3_ff) & pin_filt_ff);
      pin_prev_ff <= pin_filt_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xfer_ff <= 1'b0;
    end else begin
      xfer_ff <= pin_filt_ff[PIN_XFER] & ~pin_prev_ff[PIN_XFER];
    end
  end

  // ---------------- prescalers ----------------
  always_ff @(posedge ref_clk) begin
    if (reset || div_wr) begin
      pre_cnt_ff  <= '0;
      cnt_tick_ff <= 1'b0;
    end else if (pre_cnt_ff == cnt_divisor(div_ff) - 6'h01) begin
      pre_cnt_ff  <= '0;
      cnt_tick_ff <= 1'b1;
    end else begin
      pre_cnt_ff  <= pre_cnt_ff + 6'h01;
      cnt_tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || div_wr) begin
      dly_cnt_ff  <= '0;
      dly_tick_ff <= 1'b0;
    end else if (dly_cnt_ff == dly_divisor(div_ff) - 3'h1) begin
      dly_cnt_ff  <= '0;
      dly_tick_ff <= 1'b1;
    end else begin
      dly_cnt_ff  <= dly_cnt_ff + 3'h1;
      dly_tick_ff <= 1'b0;
    end
  end

  assign ctl.transfer = xfer_ff;
  assign ctl.cnt_tick = cnt_tick_ff;
  assign ctl.dly_tick = dly_tick_ff;
  assign ctl.dead_sel = dead_ff;

  // ---------------- channels ----------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    pwm_channel u_ch (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .ctl        (ctl.chan),
      .load_value (phase_val_ff[c]),
      .source     (src[c]),
      .delayed    (dly[c])
    );
  end

  // ---------------- status hold and interlock ----------------
  always_comb begin
    nxt_hold = hold_ff;
    if (pin_filt_ff[PIN_CLR]) begin
      nxt_hold = 1'b0;
    end
    if (pin_filt_ff[PIN_SET]) begin
      nxt_hold = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end

  assign status_out = hold_ff;
  assign force_high = pin_filt_ff[PIN_INH] | hold_ff;

  // low turns a transistor on; a leg goes low only when both
  // the source and its delayed copy agree
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      norm_n_ff <= '1;
      comp_n_ff <= '1;
    end else if (force_high) begin
      norm_n_ff <= '1;
      comp_n_ff <= '1;
    end else begin
      norm_n_ff <= ~(src & dly);
      comp_n_ff <= src | dly;
    end
  end

  assign phase_one_normal_drive       = norm_n_ff[0];
  assign phase_one_complement_drive   = comp_n_ff[0];
  assign phase_two_normal_drive       = norm_n_ff[1];
  assign phase_two_complement_drive   = comp_n_ff[1];
  assign phase_three_normal_drive     = norm_n_ff[2];
  assign phase_three_complement_drive = comp_n_ff[2];

  // ---------------- interrupts ----------------
  assign events = {
    pin_filt_ff[PIN_INH] & ~pin_prev_ff[PIN_INH],
    xfer_ff,
    nxt_hold & ~hold_ff
  };

  // write one to clear; a new event wins over the clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (reg_wr && reg_addr == OFF_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[EV_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat_ff <= RST_EV;
      irq_ff      <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  // irq follows a mask write in the same cycle as the new mask
  assign nxt_irq_mask = (reg_wr && reg_addr == OFF_IRQ_MASK)
                      ? reg_wdata[EV_W-1:0] : irq_mask_ff;

  assign irq = irq_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_even_gap;
    !dly_tick_ff [*3] ##1 dly_tick_ff;
  endsequence
  sequence s_odd_gap;
    !dly_tick_ff [*5] ##1 dly_tick_ff;
  endsequence

  a_even_shift_rate: assert property (
    disable iff (reset || div_wr)
    dly_tick_ff && !div_ff[0] |=> s_even_gap)
    else $error("even setting shift period not four");
  a_odd_shift_rate: assert property (
    disable iff (reset || div_wr)
    dly_tick_ff && div_ff[0] |=> s_odd_gap)
    else $error("odd setting shift period not six");
  a_inhibit_forces: assert property (
    pin_filt_ff[PIN_INH] |=> (&norm_n_ff && &comp_n_ff))
    else $error("inhibit did not force outputs high");
  a_hold_forces: assert property (
    hold_ff |=> (&norm_n_ff && &comp_n_ff))
    else $error("hold did not force outputs high");
  a_status_set: assert property (
    pin_filt_ff[PIN_SET] |=> status_out [*2])
    else $error("status not raised by set");
  a_status_clear: assert property (
    pin_filt_ff[PIN_CLR] && !pin_filt_ff[PIN_SET] |=> !status_out)
    else $error("status not cleared");
  a_hold_persists: assert property (
    hold_ff && !pin_filt_ff[PIN_CLR] |=> hold_ff)
    else $error("hold dropped without clear");
  a_zero_dead_pair: assert property (
    dead_ff == RST_DEAD && !force_high |=> comp_n_ff == ~norm_n_ff)
    else $error("pair not complementary at zero dead time");
  a_never_both_low: assert property (
    (norm_n_ff | comp_n_ff) == '1)
    else $error("both legs of a pair low");
  a_follow_source: assert property (
    !force_high && dead_ff == RST_DEAD |=> norm_n_ff == ~$past(src))
    else $error("normal leg does not follow its source");
  a_irq_level: assert property (
    |(irq_stat_ff & irq_mask_ff) |-> irq)
    else $error("irq low with unmasked status");
  a_read_slot: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its slot");

endmodule : dead_time_output_interlock
`default_nettype wire

// ==== dead_time_output_interlock_test.sv ====
// self-checking bench for the three-phase output stage
`timescale 1ns/1ps
`default_nettype none
module dead_time_output_interlock_test;
  import pwm_out_pkg::*;
  logic              ref_clk   = 1'b0;
  logic              reset     = 1'b1;
  logic [ADDR_W-1:0] reg_addr  = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic              inhibit   = 1'b1;
  logic [2:0]        pins      = 3'h0;
  wire logic [DATA_W-1:0] reg_rdata;
  wire logic              status_out;
  wire logic              irq;
  wire logic [2:0]        nrm;
  wire logic [2:0]        cmp;
  wire logic              shoot;
  int          miscompares = 0;
  int          compares    = 0;
  int          nl[3];
  int          ch[3];
  int          lows;
  int          n[3];
  logic [31:0] seed        = 32'h37D67C21;
  int          cnt_tab[8]  = '{4, 6, 8, 12, 16, 24, 32, 48};
  int          cs[4][2]    = '{'{0, 15}, '{1, 1}, '{3, 7}, '{7, 15}};

  always #5 ref_clk = ~ref_clk;

  dead_time_output_interlock u_dut (
    .ref_clk                      (ref_clk),
    .reset                        (reset),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_rdata                    (reg_rdata),
    .transfer_pin                 (pins[0]),
    .inhibit_pin                  (inhibit),
    .set_status_pin               (pins[1]),
    .clear_status_pin             (pins[2]),
    .status_out                   (status_out),
    .irq                          (irq),
    .phase_one_normal_drive       (nrm[0]),
    .phase_one_complement_drive   (cmp[0]),
    .phase_two_normal_drive       (nrm[1]),
    .phase_two_complement_drive   (cmp[1]),
    .phase_three_normal_drive     (nrm[2]),
    .phase_three_complement_drive (cmp[2])
  );

  half_bridge_stage u_stage (
    .ref_clk          (ref_clk),
    .reset            (reset),
    .normal_drive     (nrm),
    .complement_drive (cmp),
    .shoot_through    (shoot)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rng(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    check({24'h0, reg_rdata}, {24'h0, exp});
  endtask : rd

  task automatic pin(input logic [2:0] m);
    @(posedge ref_clk);
    pins <= m;
    repeat (4) @(posedge ref_clk);
    pins <= 3'h0;
    repeat (4) @(posedge ref_clk);
  endtask : pin

  // fire one transfer and count low and high cycles per pair
  task automatic fire(input int span, input bit zero_dead);
    nl   = '{0, 0, 0};
    ch   = '{0, 0, 0};
    lows = 0;
    @(posedge ref_clk);
    pins[0] <= 1'b1;
    for (int t = 0; t < span; t++) begin
      @(posedge ref_clk);
      if (t == 3) pins[0] <= 1'b0;
      @(negedge ref_clk);
      for (int i = 0; i < 3; i++) begin
        nl[i] += int'(!nrm[i]);
        ch[i] += int'(cmp[i]);
        lows  += int'(!nrm[i]) + int'(!cmp[i]);
        if (zero_dead) check({31'h0, cmp[i]}, {31'h0, ~nrm[i]});
      end
    end
  endtask : fire

  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200_000;
    miscompares++;
    give_verdict();
  end

  initial begin
    int d;
    int w;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check({nrm, cmp, status_out, irq, reg_rdata}, 16'hFC00);
    for (int a = 0; a < 7; a++) if (a != 5) rd(a[2:0], 8'h00);
    rd(3'h7, 8'h02);
    for (int i = 0; i < 3; i++) wr(i[2:0], 8'h20);
    fire(300, 1'b0);
    check(lows, 0);
    @(posedge ref_clk);
    inhibit <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'h0F);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h07);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    for (int i = 0; i < 3; i++) begin
      n[i] = 8 + int'(xs() % 32);
      wr(i[2:0], n[i][7:0]);
    end
    fire(200, 1'b1);
    for (int i = 0; i < 3; i++) rng(nl[i], 4 * n[i] - 4, 4 * n[i] + 2);
    foreach (cs[c]) begin
      d = cs[c][0][0] ? 6 : 4;
      w = cnt_tab[cs[c][0]] * 60;
      wr(3'h4, cs[c][0][7:0]);
      wr(3'h3, cs[c][1][7:0]);
      wr(3'h0, 8'h3C);
      fire(w + 130, 1'b0);
      rng(ch[0] - nl[0], 2 * cs[c][1] * d - 2 * d - 1, 2 * cs[c][1] * d + 2 * d + 1);
      rng(ch[0] + nl[0], 2 * w - 2 * cnt_tab[cs[c][0]] - 2 * d, 2 * w + 2 * d + 4);
    end
    check(shoot, 0);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h07);
    wr(3'h6, 8'h07);
    pin(3'h2);
    check(status_out, 1);
    rd(3'h5, 8'h01);
    check(irq, 1);
    wr(3'h6, 8'h06);
    repeat (2) @(negedge ref_clk);
    check(irq, 0);
    fire(400, 1'b0);
    check(lows, 0);
    check(status_out, 1);
    check(irq, 1);
    wr(3'h5, 8'h03);
    repeat (2) @(negedge ref_clk);
    check(irq, 0);
    pin(3'h4);
    check(status_out, 0);
    fire(400, 1'b0);
    rng(nl[0], 1, 400);
    pin(3'h6);
    check(status_out, 1);
    check(shoot, 0);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check({status_out, nrm, cmp}, 7'h3F);
    give_verdict();
  end
endmodule : dead_time_output_interlock_test
`default_nettype wire

// ==== half_bridge_stage.sv ====
// half-bridge power stage model: latches any pair switched on together
`timescale 1ns/1ps
`default_nettype none
module half_bridge_stage (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [2:0] normal_drive,
  input  wire logic [2:0] complement_drive,
  output logic            shoot_through
);
  // low drive turns a transistor on; both low shorts the rail
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shoot_through <= 1'b0;
    end else if ((~normal_drive & ~complement_drive) != 3'h0) begin
      shoot_through <= 1'b1;
    end
  end
endmodule : half_bridge_stage
`default_nettype wire

// ==== pwm_channel.sv ====
// one modulator channel: down-counter pulse source and delay line
`timescale 1ns/1ps
`default_nettype none
module pwm_channel
  import pwm_out_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  pwm_ctrl_if.chan               ctl,
  input  wire logic [DATA_W-1:0] load_value,
  output logic                   source,
  output logic                   delayed
);

  logic [DATA_W-1:0]    count_ff;
  logic [SHIFT_LEN-1:0] shreg_ff;

  // load on transfer, run down to zero, then stop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_ff <= RST_PHASE;
    end else if (ctl.transfer) begin
      count_ff <= load_value;
    end else if (ctl.cnt_tick && count_ff != RST_PHASE) begin
      count_ff <= count_ff - 8'h01;
    end
  end

  assign source = (count_ff != RST_PHASE);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shreg_ff <= '0;
    end else if (ctl.dly_tick) begin
      shreg_ff <= {shreg_ff[SHIFT_LEN-2:0], source};
    end
  end

  // zero selects the undelayed source
  always_comb begin
    if (ctl.dead_sel == RST_DEAD) begin
      delayed = source;
    end else begin
      delayed = shreg_ff[4'(ctl.dead_sel - 4'h1)];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_counter_load: assert property (
    ctl.transfer && load_value != RST_PHASE |=> source)
    else $error("source not started by transfer");
  a_counter_end: assert property (
    !ctl.transfer && count_ff == 8'h01 && ctl.cnt_tick |=> !source)
    else $error("source did not end at zero");
  a_shift_stage: assert property (
    ctl.dly_tick |=> shreg_ff[0] == $past(source))
    else $error("delay line did not take the source");
  a_rise_delayed: assert property (
    $rose(source) && ctl.dead_sel != RST_DEAD |-> !delayed)
    else $error("activating edge not delayed");

endmodule : pwm_channel
`default_nettype wire

// ==== pwm_ctrl_if.sv ====
// shared timing and setting signals from the stage to its channels
`timescale 1ns/1ps
`default_nettype none
interface pwm_ctrl_if;
  import pwm_out_pkg::*;
  logic              transfer;
  logic              cnt_tick;
  logic              dly_tick;
  logic [DEAD_W-1:0] dead_sel;
  modport ctrl (output transfer, output cnt_tick, output dly_tick,
                output dead_sel);
  modport chan (input transfer, input cnt_tick, input dly_tick,
                input dead_sel);
endinterface : pwm_ctrl_if
`default_nettype wire

// ==== pwm_out_pkg.sv ====
// constants and helpers shared by the output stage modules
package pwm_out_pkg;

  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned NUM_CH    = 3;
  localparam int unsigned SHIFT_LEN = 15;
  localparam int unsigned DEAD_W    = 4;
  localparam int unsigned DIV_W     = 3;
  localparam int unsigned PRE_W     = 6;
  localparam int unsigned DLY_W     = 3;
  localparam int unsigned EV_W      = 3;
  localparam int unsigned PIN_W     = 4;

  localparam logic [ADDR_W-1:0] OFF_PHASE1   = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_PHASE2   = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_PHASE3   = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_DEAD     = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_DIV      = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h6;
  localparam logic [ADDR_W-1:0] OFF_LIVE     = 3'h7;

  localparam logic [DATA_W-1:0] RST_PHASE = 8'h00;
  localparam logic [DEAD_W-1:0] RST_DEAD  = 4'h0;
  localparam logic [DIV_W-1:0]  RST_DIV   = 3'h0;
  localparam logic [EV_W-1:0]   RST_EV    = 3'h0;

  // interrupt event bits
  localparam int unsigned EV_HOLD = 0;
  localparam int unsigned EV_XFER = 1;
  localparam int unsigned EV_INH  = 2;

  // synchronised pin slots
  localparam int unsigned PIN_XFER = 0;
  localparam int unsigned PIN_INH  = 1;
  localparam int unsigned PIN_SET  = 2;
  localparam int unsigned PIN_CLR  = 3;

  // live register field positions
  localparam int unsigned LIVE_HOLD = 0;
  localparam int unsigned LIVE_INH  = 1;
  localparam int unsigned LIVE_SRC  = 2;

  localparam logic [DLY_W-1:0] DLY_DIV_EVEN = 3'h4;
  localparam logic [DLY_W-1:0] DLY_DIV_ODD  = 3'h6;

  function automatic logic [PRE_W-1:0] cnt_divisor(
    input logic [DIV_W-1:0] div
  );
    case (div)
      3'h0:    cnt_divisor = 6'h04;
      3'h1:    cnt_divisor = 6'h06;
      3'h2:    cnt_divisor = 6'h08;
      3'h3:    cnt_divisor = 6'h0C;
      3'h4:    cnt_divisor = 6'h10;
      3'h5:    cnt_divisor = 6'h18;
      3'h6:    cnt_divisor = 6'h20;
      default: cnt_divisor = 6'h30;
    endcase
  endfunction : cnt_divisor

  function automatic logic [DLY_W-1:0] dly_divisor(
    input logic [DIV_W-1:0] div
  );
    dly_divisor = div[0] ? DLY_DIV_ODD : DLY_DIV_EVEN;
  endfunction : dly_divisor

endpackage : pwm_out_pkg
